// [pkg/bxa_regs.vh]
/*
  Constants for the byte ALU and multiplier: register offsets, opcodes,
  flag positions, reset values and cycle counts.
  Assumes it is included by its bare name from the design file.
*/
`ifndef BXA_REGS_VH
`define BXA_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BXA_OFS_CMD 8'h00
`define BXA_OFS_OPA 8'h04
`define BXA_OFS_OPB 8'h08
`define BXA_OFS_IMM 8'h0c
`define BXA_OFS_OPAH 8'h10
`define BXA_OFS_FLAGS 8'h14
`define BXA_OFS_PROD 8'h18
`define BXA_OFS_STAT 8'h1c

// ----------------------------------------
// Opcodes written to the command register
// ----------------------------------------
`define BXA_OP_ADD_REGS 5'h00
`define BXA_OP_ADD_CARRY 5'h01
`define BXA_OP_WORD_ADD_IMM 5'h02
`define BXA_OP_SUB_REGS 5'h03
`define BXA_OP_SUBTRACT_IMM 5'h04
`define BXA_OP_SUB_BORROW 5'h05
`define BXA_OP_SUB_BORROW_IMM 5'h06
`define BXA_OP_WORD_SUB_IMM 5'h07
`define BXA_OP_AND_REGS 5'h08
`define BXA_OP_LOGIC_AND_IMM 5'h09
`define BXA_OP_OR_REGS 5'h0a
`define BXA_OP_LOGIC_OR_IMM 5'h0b
`define BXA_OP_XOR_REGS 5'h0c
`define BXA_OP_BIT_SET_MASK 5'h0d
`define BXA_OP_BIT_CLEAR_MASK 5'h0e
`define BXA_OP_ZERO_SIGN_TEST 5'h0f
`define BXA_OP_PRODUCT_UNSIGNED 5'h10
`define BXA_OP_PRODUCT_SIGNED 5'h11
`define BXA_OP_PRODUCT_MIXED 5'h12
`define BXA_OP_FRAC_PRODUCT_UNSIGNED 5'h13
`define BXA_OP_FRAC_PRODUCT_SIGNED 5'h14
`define BXA_OP_FRAC_PRODUCT_MIXED 5'h15

// ----------------------------------------
// Flag bit positions and constants
// ----------------------------------------
`define BXA_FLG_C 0
`define BXA_FLG_Z 1
`define BXA_FLG_N 2
`define BXA_FLG_V 3
`define BXA_FLG_S 4
`define BXA_FLG_H 5
`define BXA_FLAGS_RST 6'h00
`define BXA_BYTE_RST 8'h00
`define BXA_FULL_MASK 8'hff
`define BXA_CYC_SHORT 1'b0
`define BXA_CYC_LONG 1'b1

`endif

// [rtl/bxa_alu.v]
/*
  Byte ALU and 2-cycle multiplier with an AHB-Lite register slave.
  Assumes a single AHB-Lite master issuing single word transfers; hready
  is the bus ready fed back from this slave's hreadyout.
*/
`timescale 1ns/1ps
`include "bxa_regs.vh"

module bxa_alu #(
  parameter ADDR_W = 8,
  parameter WIMM_W = 6
) (
  input wire sys_clk,
  input wire rst_n,
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  output wire [5:0] flags_out,
  output wire busy_out
);

  // ----------------------------------------
  // Bus and state registers
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg wr_pend_reg;
  reg [7:0] waddr_reg;
  reg state_reg;
  reg step_reg;
  reg done_reg;
  reg [4:0] op_reg;
  reg [7:0] opa_reg;
  reg [7:0] opah_reg;
  reg [7:0] opb_reg;
  reg [7:0] imm_reg;
  reg [5:0] flags_reg;
  reg [15:0] prod_reg;

  wire addr_take;
  wire [7:0] raddr;
  wire start;
  reg [31:0] rdata_next;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign flags_out = flags_reg;
  assign busy_out = state_reg;
  assign addr_take = hsel & hready & htrans[1];
  assign raddr = haddr[7:0];
  assign start = wr_pend_reg & (waddr_reg == `BXA_OFS_CMD) & (state_reg == ST_IDLE);

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  reg [7:0] b_sel;
  reg cin;
  reg [8:0] sum9;
  reg [8:0] dif9;
  reg [15:0] word_in;
  reg [15:0] wimm;
  reg [16:0] wsum;
  reg [16:0] wdif;
  reg sgn_a;
  reg sgn_b;
  reg [17:0] mprod;
  reg [7:0] res8;
  reg [15:0] res16;
  reg [5:0] flags_next;
  reg [1:0] dest;
  reg need_long;

  always @* begin
    b_sel = opb_reg;
    cin = 1'b0;
    sgn_a = 1'b0;
    sgn_b = 1'b0;
    case (op_reg)
      `BXA_OP_SUBTRACT_IMM, `BXA_OP_SUB_BORROW_IMM, `BXA_OP_LOGIC_AND_IMM,
      `BXA_OP_LOGIC_OR_IMM, `BXA_OP_BIT_SET_MASK: begin
        b_sel = imm_reg;
      end
      `BXA_OP_BIT_CLEAR_MASK: begin
        b_sel = `BXA_FULL_MASK - imm_reg;
      end
      `BXA_OP_ZERO_SIGN_TEST: begin
        b_sel = opa_reg;
      end
      default: begin
        b_sel = opb_reg;
      end
    endcase
    if ((op_reg == `BXA_OP_ADD_CARRY) || (op_reg == `BXA_OP_SUB_BORROW) ||
        (op_reg == `BXA_OP_SUB_BORROW_IMM)) begin
      cin = flags_reg[`BXA_FLG_C];
    end
    if ((op_reg == `BXA_OP_PRODUCT_SIGNED) || (op_reg == `BXA_OP_FRAC_PRODUCT_SIGNED)) begin
      sgn_a = opa_reg[7];
      sgn_b = opb_reg[7];
    end
    if ((op_reg == `BXA_OP_PRODUCT_MIXED) || (op_reg == `BXA_OP_FRAC_PRODUCT_MIXED)) begin
      sgn_a = opa_reg[7];
    end
    sum9 = {1'b0, opa_reg} + {1'b0, b_sel} + {8'h00, cin};
    dif9 = {1'b0, opa_reg} - {1'b0, b_sel} - {8'h00, cin};
    word_in = {opah_reg, opa_reg};
    wimm = {{(16-WIMM_W){1'b0}}, imm_reg[WIMM_W-1:0]};
    wsum = {1'b0, word_in} + {1'b0, wimm};
    wdif = {1'b0, word_in} - {1'b0, wimm};
    mprod = $signed({{10{sgn_a}}, opa_reg}) * $signed({{10{sgn_b}}, opb_reg});
    res8 = opa_reg;
    res16 = word_in;
    flags_next = flags_reg;
    dest = 2'd3;
    need_long = `BXA_CYC_SHORT;
    case (op_reg)
      `BXA_OP_ADD_REGS, `BXA_OP_ADD_CARRY: begin
        res8 = sum9[7:0];
        dest = 2'd0;
        flags_next[`BXA_FLG_C] = sum9[8];
        flags_next[`BXA_FLG_H] = (opa_reg[3] & b_sel[3]) | (b_sel[3] & ~sum9[3]) | (~sum9[3] & opa_reg[3]);
        flags_next[`BXA_FLG_V] = (opa_reg[7] & b_sel[7] & ~sum9[7]) | (~opa_reg[7] & ~b_sel[7] & sum9[7]);
        flags_next[`BXA_FLG_N] = sum9[7];
        flags_next[`BXA_FLG_Z] = (sum9[7:0] == 8'h00);
      end
      `BXA_OP_SUB_REGS, `BXA_OP_SUBTRACT_IMM, `BXA_OP_SUB_BORROW, `BXA_OP_SUB_BORROW_IMM: begin
        res8 = dif9[7:0];
        dest = 2'd0;
        flags_next[`BXA_FLG_C] = dif9[8];
        flags_next[`BXA_FLG_H] = (~opa_reg[3] & b_sel[3]) | (b_sel[3] & dif9[3]) | (dif9[3] & ~opa_reg[3]);
        flags_next[`BXA_FLG_V] = (opa_reg[7] & ~b_sel[7] & ~dif9[7]) | (~opa_reg[7] & b_sel[7] & dif9[7]);
        flags_next[`BXA_FLG_N] = dif9[7];
        flags_next[`BXA_FLG_Z] = (dif9[7:0] == 8'h00);
      end
      `BXA_OP_WORD_ADD_IMM: begin
        res16 = wsum[15:0];
        dest = 2'd1;
        need_long = `BXA_CYC_LONG;
        flags_next[`BXA_FLG_C] = ~wsum[15] & word_in[15];
        flags_next[`BXA_FLG_V] = ~word_in[15] & wsum[15];
        flags_next[`BXA_FLG_N] = wsum[15];
        flags_next[`BXA_FLG_S] = wsum[15] ^ (~word_in[15] & wsum[15]);
        flags_next[`BXA_FLG_Z] = (wsum[15:0] == 16'h0000);
      end
      `BXA_OP_WORD_SUB_IMM: begin
        res16 = wdif[15:0];
        dest = 2'd1;
        need_long = `BXA_CYC_LONG;
        flags_next[`BXA_FLG_C] = wdif[15] & ~word_in[15];
        flags_next[`BXA_FLG_V] = word_in[15] & ~wdif[15];
        flags_next[`BXA_FLG_N] = wdif[15];
        flags_next[`BXA_FLG_S] = wdif[15] ^ (word_in[15] & ~wdif[15]);
        flags_next[`BXA_FLG_Z] = (wdif[15:0] == 16'h0000);
      end
      `BXA_OP_AND_REGS, `BXA_OP_LOGIC_AND_IMM, `BXA_OP_BIT_CLEAR_MASK, `BXA_OP_ZERO_SIGN_TEST: begin
        res8 = opa_reg & b_sel;
        dest = 2'd0;
        flags_next[`BXA_FLG_V] = 1'b0;
        flags_next[`BXA_FLG_N] = res8[7];
        flags_next[`BXA_FLG_Z] = (res8 == 8'h00);
      end
      `BXA_OP_OR_REGS, `BXA_OP_LOGIC_OR_IMM, `BXA_OP_BIT_SET_MASK: begin
        res8 = opa_reg | b_sel;
        dest = 2'd0;
        flags_next[`BXA_FLG_V] = 1'b0;
        flags_next[`BXA_FLG_N] = res8[7];
        flags_next[`BXA_FLG_Z] = (res8 == 8'h00);
      end
      `BXA_OP_XOR_REGS: begin
        res8 = opa_reg ^ b_sel;
        dest = 2'd0;
        flags_next[`BXA_FLG_V] = 1'b0;
        flags_next[`BXA_FLG_N] = res8[7];
        flags_next[`BXA_FLG_Z] = (res8 == 8'h00);
      end
      `BXA_OP_PRODUCT_UNSIGNED, `BXA_OP_PRODUCT_SIGNED, `BXA_OP_PRODUCT_MIXED: begin
        res16 = mprod[15:0];
        dest = 2'd2;
        need_long = `BXA_CYC_LONG;
        flags_next[`BXA_FLG_C] = mprod[15];
        flags_next[`BXA_FLG_Z] = (mprod[15:0] == 16'h0000);
      end
      `BXA_OP_FRAC_PRODUCT_UNSIGNED, `BXA_OP_FRAC_PRODUCT_SIGNED, `BXA_OP_FRAC_PRODUCT_MIXED: begin
        res16 = {mprod[14:0], 1'b0};
        dest = 2'd2;
        need_long = `BXA_CYC_LONG;
        flags_next[`BXA_FLG_C] = mprod[15];
        flags_next[`BXA_FLG_Z] = (mprod[14:0] == 15'h0000);
      end
      default: begin
        dest = 2'd3;
      end
    endcase
  end

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always @* begin
    rdata_next = 32'h00000000;
    case (raddr)
      `BXA_OFS_CMD: begin
        rdata_next = {27'h0, op_reg};
      end
      `BXA_OFS_OPA: begin
        rdata_next = {24'h000000, opa_reg};
      end
      `BXA_OFS_OPB: begin
        rdata_next = {24'h000000, opb_reg};
      end
      `BXA_OFS_IMM: begin
        rdata_next = {24'h000000, imm_reg};
      end
      `BXA_OFS_OPAH: begin
        rdata_next = {24'h000000, opah_reg};
      end
      `BXA_OFS_FLAGS: begin
        rdata_next = {26'h0, flags_reg};
      end
      `BXA_OFS_PROD: begin
        rdata_next = {16'h0000, prod_reg};
      end
      `BXA_OFS_STAT: begin
        rdata_next = {30'h0, done_reg, state_reg};
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------
  // Bus slave and sequencing
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= `BXA_BYTE_RST;
      hrdata <= 32'h00000000;
      state_reg <= ST_IDLE;
      step_reg <= 1'b0;
      done_reg <= 1'b0;
      op_reg <= 5'h00;
      opa_reg <= `BXA_BYTE_RST;
      opah_reg <= `BXA_BYTE_RST;
      opb_reg <= `BXA_BYTE_RST;
      imm_reg <= `BXA_BYTE_RST;
      flags_reg <= `BXA_FLAGS_RST;
      prod_reg <= 16'h0000;
    end else begin
      wr_pend_reg <= addr_take & hwrite;
      if (addr_take) begin
        waddr_reg <= raddr;
      end
      if (addr_take & ~hwrite) begin
        hrdata <= rdata_next;
      end
      if (wr_pend_reg && (state_reg == ST_IDLE)) begin
        case (waddr_reg)
          `BXA_OFS_OPA: opa_reg <= hwdata[7:0];
          `BXA_OFS_OPB: opb_reg <= hwdata[7:0];
          `BXA_OFS_IMM: imm_reg <= hwdata[7:0];
          `BXA_OFS_OPAH: opah_reg <= hwdata[7:0];
          `BXA_OFS_FLAGS: flags_reg <= hwdata[5:0];
          default: ;
        endcase
      end
      if (start) begin
        op_reg <= hwdata[4:0];
        state_reg <= ST_RUN;
        step_reg <= 1'b0;
        done_reg <= 1'b0;
      end else if (state_reg == ST_RUN) begin
        if (step_reg == need_long) begin
          state_reg <= ST_IDLE;
          done_reg <= 1'b1;
          flags_reg <= flags_next;
          if (dest == 2'd0) begin
            opa_reg <= res8;
          end
          if (dest == 2'd1) begin
            opa_reg <= res16[7:0];
            opah_reg <= res16[15:8];
          end
          if (dest == 2'd2) begin
            prod_reg <= res16;
          end
        end else begin
          step_reg <= 1'b1;
        end
      end
    end
  end

endmodule

// [testbench/bxa_alu_monitor.sv]
/*
  Checker for the byte ALU, bound to the top module ports.
  Assumes hready is fed back from hreadyout.
*/
`timescale 1ns/1ps
module bxa_alu_monitor #(
  parameter ADDR_W = 8
) (
  input wire sys_clk,
  input wire rst_n,
  input wire hsel,
  input wire [ADDR_W-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [5:0] flags_out,
  input wire busy_out
);
  // ----
  // Command start tracking.
  // ----
  logic cmd_ap_reg;
  wire [4:0] op = hwdata[4:0];
  wire go = cmd_ap_reg & ~busy_out;
  wire wrd = go & (op == 5'h02 | op == 5'h07);
  wire lng = wrd | (go & op >= 5'h10 & op <= 5'h15);
  wire lgc = go & op >= 5'h08 & op <= 5'h0f;
  wire ari = go & op <= 5'h06 & op != 5'h02;
  always @(posedge sys_clk) begin
    cmd_ap_reg <= rst_n & hsel & hready & htrans[1] & hwrite & (haddr == '0);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_short_len: assert property (go && !lng |=> busy_out ##1 !busy_out)
    else $error("short op length wrong");
  a_long_len: assert property (lng |=> busy_out [*2] ##1 !busy_out)
    else $error("long op length wrong");
  a_logic_keep: assert property (lgc |=> ##1 (flags_out & 6'h31) == ($past(flags_out, 2) & 6'h31))
    else $error("logic op changed C S H");
  a_logic_v: assert property (lgc |=> ##1 !flags_out[3])
    else $error("logic op left V set");
  a_byte_s: assert property (ari |=> ##1 (flags_out & 6'h10) == ($past(flags_out, 2) & 6'h10))
    else $error("byte op changed S");
  a_word_h: assert property (wrd |=> ##2 (flags_out & 6'h20) == ($past(flags_out, 3) & 6'h20))
    else $error("word op changed H");
  a_word_sign: assert property (wrd |=> ##2 flags_out[4] == (flags_out[2] ^ flags_out[3]))
    else $error("word op S wrong");
  a_mul_keep: assert property (lng && !wrd |=> ##2 (flags_out & 6'h3c) == ($past(flags_out, 3) & 6'h3c))
    else $error("multiply changed N V S H");
endmodule

bind bxa_alu bxa_alu_monitor #(.ADDR_W(ADDR_W)) bxa_alu_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .flags_out(flags_out), .busy_out(busy_out));

// [testbench/bxa_host_model.sv]
/*
  Bus master standing in for the decoder and register file side.
  Assumes one slave whose hreadyout is looped back as hready.
*/
`timescale 1ns/1ps
module bxa_host_model (
  input wire sys_clk,
  input wire hready,
  input wire [31:0] hrdata,
  output logic hsel,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h5a5a5a5a;
  end
  // ----
  // Single word transfer, entered just after a rising edge.
  // ----
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule

// [testbench/bxa_alu_tb.sv]
/*
  Self-checking bench: every opcode over several operand sets.
  Assumes the bus master model and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "bxa_regs.vh"
module bxa_alu_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  wire hsel, hwrite, hreadyout, hresp, busy_out;
  wire [7:0] haddr;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] hwdata, hrdata;
  wire [5:0] flags_out;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] ea, eah, eb, ek;
  logic [5:0] ef;
  logic [15:0] ep = 16'h0000;
  logic [31:0] q;
  always #5 sys_clk = ~sys_clk;
  bxa_alu #(.ADDR_W(8), .WIMM_W(6)) bxa_alu_i (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flags_out(flags_out), .busy_out(busy_out));
  bxa_host_model bxa_host_model_i (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // ----
  // Shared tasks.
  // ----
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bxa_host_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    bxa_host_model_i.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic load(input logic [7:0] a, b, k, ah, input logic [5:0] f);
    ea = a;
    eb = b;
    ek = k;
    eah = ah;
    ef = f;
    wr(`BXA_OFS_OPA, {24'h0, a});
    wr(`BXA_OFS_OPB, {24'h0, b});
    wr(`BXA_OFS_IMM, {24'h0, k});
    wr(`BXA_OFS_OPAH, {24'h0, ah});
    wr(`BXA_OFS_FLAGS, {26'h0, f});
  endtask
  task automatic settle;
    int n;
    n = 0;
    do begin
      rd(`BXA_OFS_STAT);
      n++;
    end while (q[0] !== 1'b0 && n < 20);
    chk("status", 32'h2, q);
    chk("busy pin", 32'h0, {31'h0, busy_out});
  endtask
  task automatic model(input logic [4:0] op);
    logic [8:0] r;
    logic [4:0] h;
    logic [16:0] w;
    logic [15:0] sa, sb;
    logic [7:0] y;
    logic ci;
    y = (op inside {5'h04, 5'h06, 5'h09, 5'h0b, 5'h0d, 5'h0e}) ? ek : eb;
    ci = (op inside {5'h01, 5'h05, 5'h06}) & ef[0];
    sa = (op inside {5'h11, 5'h12, 5'h14, 5'h15}) ? {{8{ea[7]}}, ea} : {8'h00, ea};
    sb = (op inside {5'h11, 5'h14}) ? {{8{eb[7]}}, eb} : {8'h00, eb};
    r = 9'h000;
    h = 5'h00;
    case (op)
      5'h00, 5'h01: begin
        r = ea + y + ci;
        h = ea[3:0] + y[3:0] + ci;
        ef[3] = ea[7] == y[7] && r[7] != ea[7];
      end
      5'h03, 5'h04, 5'h05, 5'h06: begin
        r = ea - y - ci;
        h = ea[3:0] - y[3:0] - ci;
        ef[3] = ea[7] != y[7] && r[7] != ea[7];
      end
      5'h02, 5'h07: begin
        w = op[0] ? {1'b0, eah, ea} - ek[5:0] : {1'b0, eah, ea} + ek[5:0];
        ef[3] = op[0] ? eah[7] & ~w[15] : ~eah[7] & w[15];
        ef[0] = w[16];
        ef[1] = w[15:0] == 16'h0000;
        ef[2] = w[15];
        ef[4] = w[15] ^ ef[3];
        {eah, ea} = w[15:0];
      end
      5'h08, 5'h09: r = ea & y;
      5'h0a, 5'h0b, 5'h0d: r = ea | y;
      5'h0c: r = ea ^ y;
      5'h0e: r = ea & (8'hff - y);
      5'h0f: r = ea & ea;
      5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15: begin
        ep = sa * sb;
        ef[0] = ep[15];
        if (op > 5'h12) ep = ep << 1;
        ef[1] = ep == 16'h0000;
      end
      default: ;
    endcase
    if (op <= 5'h06 && op != 5'h02) begin
      ef[0] = r[8];
      ef[5] = h[4];
    end
    if (op <= 5'h0f && op != 5'h02 && op != 5'h07) begin
      if (op >= 5'h08) ef[3] = 1'b0;
      ea = r[7:0];
      ef[1] = r[7:0] == 8'h00;
      ef[2] = r[7];
    end
  endtask
  task automatic check_all;
    rd(`BXA_OFS_OPA);
    chk("dest", {24'h0, ea}, q);
    rd(`BXA_OFS_OPAH);
    chk("dest high", {24'h0, eah}, q);
    rd(`BXA_OFS_FLAGS);
    chk("flags", {26'h0, ef}, q);
    chk("flags pin", {26'h0, ef}, {26'h0, flags_out});
    rd(`BXA_OFS_PROD);
    chk("product", {16'h0, ep}, q);
  endtask
  // ----
  // Scenarios.
  // ----
  task automatic t_reset_map;
    for (int i = 0; i < 10; i++) begin
      rd(8'(i * 4));
      chk("reset value", 32'h0, q);
    end
    wr(8'h20, 32'hffffffff);
    wr(`BXA_OFS_PROD, 32'hffffffff);
    rd(8'h20);
    chk("unmapped", 32'h0, q);
    rd(`BXA_OFS_PROD);
    chk("product", 32'h0, q);
  endtask
  task automatic t_all_ops(input logic [7:0] a, b, k, ah, input logic [5:0] f);
    for (int op = 0; op <= 22; op++) begin
      load(a, b, k, ah, f);
      wr(`BXA_OFS_CMD, 32'(op));
      model(5'(op));
      settle;
      check_all;
    end
  endtask
  task automatic t_busy_drop;
    load(8'hc8, 8'h05, 8'h00, 8'h12, 6'h00);
    wr(`BXA_OFS_CMD, {27'h0, `BXA_OP_PRODUCT_UNSIGNED});
    wr(`BXA_OFS_CMD, {27'h0, `BXA_OP_ADD_REGS});
    model(`BXA_OP_PRODUCT_UNSIGNED);
    settle;
    check_all;
    rd(`BXA_OFS_CMD);
    chk("opcode", 32'h10, q);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset_map;
    t_all_ops(8'h7f, 8'h81, 8'h3f, 8'hff, 6'h3f);
    t_all_ops(8'h80, 8'h80, 8'h01, 8'h7f, 6'h00);
    t_all_ops(8'h00, 8'h00, 8'h00, 8'h80, 6'h15);
    t_busy_drop;
    give_verdict;
  end
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
endmodule
